// *** logic/tarp_pkg.sv ***
// How it works
// RULE_01 - each axis is driven only as a pulse line plus a direction line.
// RULE_02 - each axis takes a signed 32-bit relative count; sign is direction.
// RULE_03 - each axis keeps a 32-bit position, up forward and down in reverse.
// RULE_04 - the peak rate is clamped to between 100 Hz and 100 kHz.
// RULE_05 - the program names only the first output point, fixing four lines.
// RULE_06 - direction is low for positive motion and high for negative.
// RULE_07 - direction holds after the last pulse until the contact drops.
// RULE_08 - the shared start/end rate is clamped to at least 6 Hz.
// RULE_09 - the ramp time is clamped to at least 20 ms and defaults to 100 ms.
// RULE_10 - the Y axis uses the X start rate and ramp time during the move.
// RULE_11 - the program should not set a separate ramp-down time per axis.
// RULE_12 - pause controls have no effect; dropping the contact stops pulsing.
// RULE_13 - the move does not start while either pulse channel is busy.
// RULE_14 - the done flag sets when both axes finish their pulses.
// RULE_15 - axes are paced in proportion so both start and finish together.
package tarp_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [31:0] FREQ_MIN_HZ = 32'h0000_0064;
    localparam logic [31:0] FREQ_MAX_HZ = 32'h0001_86A0;
    localparam logic [31:0] START_MIN_HZ = 32'h0000_0006;
    localparam logic [31:0] RAMP_MIN_MS = 32'h0000_0014;
    localparam logic [31:0] RAMP_DEF_MS = 32'h0000_0064;
    // phase accumulator: rate_hz * 2^32 / CLK_HZ, scaled by a 64-bit mult
    localparam logic [31:0] PHASE_PER_HZ = 32'h0000_0056;
    localparam logic [31:0] CYC_PER_MS = 32'h0000_C350;

    typedef struct packed {
        logic x_pulse_out;
        logic x_direction_out;
        logic y_pulse_out;
        logic y_direction_out;
    } tarp_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } tarp_state_t;
endpackage : tarp_pkg

// *** logic/tarp_gen.sv ***
`timescale 1ns/10ps
module tarp_gen (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic drive_contact_i,
    input wire logic signed [31:0] x_pulse_count_i,
    input wire logic signed [31:0] y_pulse_count_i,
    input wire logic [31:0] max_freq_hz_i,
    input wire logic [31:0] start_end_frequency_setting_i,
    input wire logic [31:0] ramp_time_setting_i,
    input wire logic ramp_time_valid_i,
    input wire logic pulse_channel_a_busy_i,
    input wire logic pulse_channel_b_busy_i,
    output tarp_pkg::tarp_pins_t pins_o,
    output logic signed [31:0] x_position_o,
    output logic signed [31:0] y_position_o,
    output logic move_done_flag_o,
    output logic busy_o
);
    ////////////////////////////////////////////////////////////////////////
    // synchronisers for pin-side inputs
    logic [1:0] cont_s_q;
    logic [1:0] busa_s_q;
    logic [1:0] busb_s_q;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cont_s_q <= 2'h0;
            busa_s_q <= 2'h0;
            busb_s_q <= 2'h0;
        end else if (clk_en_i) begin
            cont_s_q <= {cont_s_q[0], drive_contact_i};
            busa_s_q <= {busa_s_q[0], pulse_channel_a_busy_i};
            busb_s_q <= {busb_s_q[0], pulse_channel_b_busy_i};
        end
    end
    logic contact;
    logic chan_busy;
    assign contact = cont_s_q[1];
    assign chan_busy = busa_s_q[1] | busb_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] clamp_lo(input logic [31:0] v,
                                             input logic [31:0] lo);
        clamp_lo = (v < lo) ? lo : v;
    endfunction : clamp_lo

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        mag = v[31] ? 32'(-v) : 32'(v);
    endfunction : mag

    function automatic logic [31:0] phase_inc(input logic [31:0] hz);
        logic [63:0] p;
        p = 64'(hz) * 64'(tarp_pkg::PHASE_PER_HZ);
        phase_inc = p[31:0];
    endfunction : phase_inc

    logic [31:0] peak_hz;
    logic [31:0] start_hz;
    logic [31:0] ramp_ms;
    always_comb begin
        peak_hz = clamp_lo(max_freq_hz_i, tarp_pkg::FREQ_MIN_HZ); // RULE_04
        if (peak_hz > tarp_pkg::FREQ_MAX_HZ) begin
            peak_hz = tarp_pkg::FREQ_MAX_HZ; // RULE_04
        end
        // shared X setting also paces Y
        start_hz = clamp_lo(start_end_frequency_setting_i,
                            tarp_pkg::START_MIN_HZ); // RULE_08 RULE_10
        if (start_hz > peak_hz) begin
            start_hz = peak_hz;
        end
        ramp_ms = ramp_time_valid_i ? ramp_time_setting_i
                                    : tarp_pkg::RAMP_DEF_MS; // RULE_09
        ramp_ms = clamp_lo(ramp_ms, tarp_pkg::RAMP_MIN_MS); // RULE_09
    end

    ////////////////////////////////////////////////////////////////////////
    // move state
    tarp_pkg::tarp_state_t st_q, st_d;
    logic busy_q, busy_d;
    logic [31:0] xl_q, xl_d, yl_q, yl_d;
    logic [31:0] long_q, long_d;
    logic [31:0] done_q, done_d;
    logic [31:0] err_q, err_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] inc_q, inc_d;
    logic [31:0] step_q, step_d;
    logic [31:0] tick_q, tick_d;
    logic xdir_q, xdir_d, ydir_q, ydir_d;
    logic xp_q, xp_d, yp_q, yp_d;
    logic signed [31:0] xpos_q, xpos_d, ypos_q, ypos_d;
    logic fin_q, fin_d;

    logic [31:0] inc_lo;
    logic [31:0] inc_hi;
    logic [32:0] acc_sum;
    logic [32:0] err_sum;
    logic [63:0] ramp_cyc;
    logic [31:0] remain;
    always_comb begin
        st_d = st_q;
        xl_d = xl_q;
        yl_d = yl_q;
        long_d = long_q;
        done_d = done_q;
        err_d = err_q;
        acc_d = acc_q;
        inc_d = inc_q;
        step_d = step_q;
        tick_d = tick_q;
        xdir_d = xdir_q;
        ydir_d = ydir_q;
        xp_d = 1'b0;
        yp_d = 1'b0;
        xpos_d = xpos_q;
        ypos_d = ypos_q;
        fin_d = fin_q;
        inc_lo = phase_inc(start_hz);
        inc_hi = phase_inc(peak_hz);
        acc_sum = 33'(acc_q) + 33'(inc_q);
        err_sum = 33'(err_q) + 33'(yl_q);
        ramp_cyc = 64'(ramp_ms) * 64'(tarp_pkg::CYC_PER_MS);
        remain = long_q - done_q;
        unique case (st_q)
            tarp_pkg::ST_IDLE: begin
                fin_d = 1'b0;
                if (contact && !chan_busy) begin // RULE_13
                    xdir_d = x_pulse_count_i[31]; // RULE_06
                    ydir_d = y_pulse_count_i[31]; // RULE_06
                    xl_d = mag(x_pulse_count_i); // RULE_02
                    yl_d = mag(y_pulse_count_i);
                    // longer axis leads, ramped from the start rate up to the peak rate
                    if (mag(x_pulse_count_i) >= mag(y_pulse_count_i)) begin
                        long_d = mag(x_pulse_count_i); // RULE_15
                    end else begin
                        long_d = mag(y_pulse_count_i); // RULE_15
                    end
                    done_d = 32'h0;
                    err_d = 32'h0;
                    acc_d = 32'h0;
                    inc_d = inc_lo;
                    tick_d = 32'h0;
                    step_d = (ramp_cyc[31:0] == 32'h0) ? 32'h1 : 32'h0;
                    if (long_d == 32'h0) begin
                        fin_d = 1'b1;
                        st_d = tarp_pkg::ST_HOLD;
                    end else begin
                        st_d = tarp_pkg::ST_RUN;
                    end
                end
            end
            tarp_pkg::ST_RUN: begin
                if (!contact) begin
                    // cut move: stop at once, direction is let go as well
                    st_d = tarp_pkg::ST_IDLE; // RULE_12
                    xdir_d = 1'b0; // RULE_07
                    ydir_d = 1'b0;
                end else begin
                    // linear ramp: retune rate every 1/64 of ramp time
                    tick_d = tick_q + 32'h1;
                    if (tick_q >= ramp_cyc[37:6]) begin
                        tick_d = 32'h0;
                        step_d = (inc_hi - inc_lo) >> 6;
                        if (remain <= done_q && inc_q > inc_lo + step_d) begin
                            inc_d = inc_q - step_d;
                        end else if (remain > done_q &&
                                     inc_q + step_d < inc_hi) begin
                            inc_d = inc_q + step_d;
                        end else if (remain > done_q) begin
                            inc_d = inc_hi;
                        end
                    end
                    acc_d = acc_sum[31:0];
                    if (acc_sum[32]) begin
                        done_d = done_q + 32'h1;
                        // bresenham: each axis pulses in its own share
                        if (xl_q == long_q) begin
                            xp_d = 1'b1;
                        end else begin
                            yp_d = 1'b1;
                        end
                        err_d = err_sum[31:0];
                        if (xl_q == long_q && err_sum >= 33'(long_q)) begin
                            yp_d = 1'b1; // RULE_15
                            err_d = 32'(err_sum - 33'(long_q));
                        end else if (xl_q != long_q) begin
                            err_d = 32'(33'(err_q) + 33'(xl_q));
                            if (33'(err_q) + 33'(xl_q) >= 33'(long_q)) begin
                                xp_d = 1'b1; // RULE_15
                                err_d = 32'(33'(err_q) + 33'(xl_q)
                                            - 33'(long_q));
                            end
                        end
                        if (xp_d) begin
                            xpos_d = xdir_q ? xpos_q - 32'sh1
                                            : xpos_q + 32'sh1; // RULE_03
                        end
                        if (yp_d) begin
                            ypos_d = ydir_q ? ypos_q - 32'sh1
                                            : ypos_q + 32'sh1; // RULE_03
                        end
                        if (done_q + 32'h1 == long_q) begin
                            fin_d = 1'b1; // RULE_14
                            st_d = tarp_pkg::ST_HOLD;
                        end
                    end
                end
            end
            tarp_pkg::ST_HOLD: begin
                // direction kept until the contact drops
                if (!contact) begin
                    st_d = tarp_pkg::ST_IDLE; // RULE_07
                    xdir_d = 1'b0;
                    ydir_d = 1'b0;
                end
            end
            default: begin
                st_d = tarp_pkg::ST_IDLE;
            end
        endcase
        busy_d = (st_d == tarp_pkg::ST_RUN);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= tarp_pkg::ST_IDLE;
            busy_q <= 1'b0;
            xl_q <= 32'h0;
            yl_q <= 32'h0;
            long_q <= 32'h0;
            done_q <= 32'h0;
            err_q <= 32'h0;
            acc_q <= 32'h0;
            inc_q <= 32'h0;
            step_q <= 32'h0;
            tick_q <= 32'h0;
            xdir_q <= 1'b0;
            ydir_q <= 1'b0;
            xp_q <= 1'b0;
            yp_q <= 1'b0;
            xpos_q <= 32'sh0;
            ypos_q <= 32'sh0;
            fin_q <= 1'b0;
        end else if (clk_en_i) begin
            st_q <= st_d;
            busy_q <= busy_d;
            xl_q <= xl_d;
            yl_q <= yl_d;
            long_q <= long_d;
            done_q <= done_d;
            err_q <= err_d;
            acc_q <= acc_d;
            inc_q <= inc_d;
            step_q <= step_d;
            tick_q <= tick_d;
            xdir_q <= xdir_d;
            ydir_q <= ydir_d;
            xp_q <= xp_d;
            yp_q <= yp_d;
            xpos_q <= xpos_d;
            ypos_q <= ypos_d;
            fin_q <= fin_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pulse and direction only, one pin group
    always_comb begin
        pins_o.x_pulse_out = xp_q; // RULE_01
        pins_o.x_direction_out = xdir_q;
        pins_o.y_pulse_out = yp_q;
        pins_o.y_direction_out = ydir_q;
    end
    assign x_position_o = xpos_q;
    assign y_position_o = ypos_q;
    assign move_done_flag_o = fin_q;
    assign busy_o = busy_q;
endmodule : tarp_gen

// *** dv/tarp_gen_chk.sv ***
`timescale 1ns/10ps
module tarp_gen_chk (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic drive_contact_i,
    input wire logic signed [31:0] x_pulse_count_i,
    input wire logic signed [31:0] y_pulse_count_i,
    input wire logic pulse_channel_a_busy_i,
    input wire logic pulse_channel_b_busy_i,
    input wire tarp_pkg::tarp_pins_t pins_o,
    input wire logic move_done_flag_o,
    input wire logic busy_o
);
    logic [31:0] ax;
    logic [31:0] ay;
    assign ax = x_pulse_count_i[31] ? -x_pulse_count_i : x_pulse_count_i;
    assign ay = y_pulse_count_i[31] ? -y_pulse_count_i : y_pulse_count_i;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////
    property p_dir_x;
        busy_o |-> pins_o.x_direction_out == x_pulse_count_i[31];
    endproperty
    a_dir_x: assert property (p_dir_x)
        else $error("x direction wrong");
    property p_dir_y;
        busy_o |-> pins_o.y_direction_out == y_pulse_count_i[31];
    endproperty
    a_dir_y: assert property (p_dir_y)
        else $error("y direction wrong");
    property p_gap;
        $rose(pins_o.x_pulse_out) |=> !pins_o.x_pulse_out [*8];
    endproperty
    a_gap: assert property (p_gap)
        else $error("x pulses too close");
    property p_stop;
        !drive_contact_i [*8] |-> !pins_o.x_pulse_out && !pins_o.y_pulse_out;
    endproperty
    a_stop: assert property (p_stop)
        else $error("pulse without contact");
    property p_rel;
        !drive_contact_i [*8] |-> !pins_o.x_direction_out &&
            !pins_o.y_direction_out;
    endproperty
    a_rel: assert property (p_rel)
        else $error("direction not released");
    property p_done_clr;
        !drive_contact_i [*8] |-> !move_done_flag_o;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("done not cleared");
    property p_done_run;
        move_done_flag_o |-> !busy_o;
    endproperty
    a_done_run: assert property (p_done_run)
        else $error("done while running");
    property p_block;
        (pulse_channel_a_busy_i || pulse_channel_b_busy_i) [*4] ##0 !busy_o
            |=> !busy_o;
    endproperty
    a_block: assert property (p_block)
        else $error("start while busy");
    property p_pair;
        drive_contact_i && ax >= ay && pins_o.y_pulse_out
            |-> pins_o.x_pulse_out;
    endproperty
    a_pair: assert property (p_pair)
        else $error("short axis out of step");
endmodule : tarp_gen_chk

bind tarp_gen tarp_gen_chk u_chk (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .drive_contact_i(drive_contact_i), .x_pulse_count_i(x_pulse_count_i),
    .y_pulse_count_i(y_pulse_count_i),
    .pulse_channel_a_busy_i(pulse_channel_a_busy_i),
    .pulse_channel_b_busy_i(pulse_channel_b_busy_i), .pins_o(pins_o),
    .move_done_flag_o(move_done_flag_o), .busy_o(busy_o));

// *** dv/tarp_drive_model.sv ***
`timescale 1ns/10ps
module tarp_drive_model (
    input wire logic sys_clk_i,
    input wire tarp_pkg::tarp_pins_t pins_i,
    output logic signed [31:0] x_steps_o,
    output logic signed [31:0] y_steps_o,
    output logic [31:0] y_alone_o,
    output logic [31:0] min_gap_o
);
    logic [31:0] gap;
    logic seen;
    initial begin
        x_steps_o = 32'sh0;
        y_steps_o = 32'sh0;
        y_alone_o = 32'h0;
        min_gap_o = 32'hFFFF_FFFF;
        gap = 32'h0;
        seen = 1'b0;
    end
    // a drive only sees pulse plus direction; high direction is reverse
    always @(posedge sys_clk_i) begin
        gap = gap + 1;
        if (pins_i.x_pulse_out) begin
            x_steps_o += pins_i.x_direction_out ? -1 : 1;
            if (seen && gap < min_gap_o) min_gap_o = gap;
            gap = 0;
            seen = 1;
        end
        if (pins_i.y_pulse_out) begin
            y_steps_o += pins_i.y_direction_out ? -1 : 1;
            if (!pins_i.x_pulse_out) y_alone_o++;
        end
    end
endmodule : tarp_drive_model

// *** dv/two_axis_relative_pulse_gen_tb.sv ***
`timescale 1ns/10ps
module two_axis_relative_pulse_gen_tb;
    logic clk, rst_n, contact, busy_a, busy_b, done, busy;
    logic signed [31:0] xc, yc, xpos, ypos, xs, ys, ex, ey, sx;
    logic [31:0] alone, gap;
    tarp_pkg::tarp_pins_t pins;
    logic [1:0] dirs;
    assign dirs = {pins.x_direction_out, pins.y_direction_out};
    int err_total = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    // four lines fixed from one destination; no separate ramp-down input
    tarp_gen dut (.sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
        .drive_contact_i(contact), .x_pulse_count_i(xc), .y_pulse_count_i(yc),
        .max_freq_hz_i(32'h0003_0D40),
        .start_end_frequency_setting_i(32'h0003_0D40),
        .ramp_time_setting_i(32'h0000_0005), .ramp_time_valid_i(1'b1),
        .pulse_channel_a_busy_i(busy_a), .pulse_channel_b_busy_i(busy_b),
        .pins_o(pins), .x_position_o(xpos),
        .y_position_o(ypos),
        .move_done_flag_o(done), .busy_o(busy));
    tarp_drive_model drv (.sys_clk_i(clk), .pins_i(pins), .x_steps_o(xs),
        .y_steps_o(ys), .y_alone_o(alone), .min_gap_o(gap));
    ////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task go(input logic signed [31:0] x, input logic signed [31:0] y);
        xc <= x;
        yc <= y;
        contact <= 1'b1;
        ex = ex + x;
        ey = ey + y;
    endtask : go
    task wait_done;
        for (int k = 0; k < 20000 && done !== 1'b1; k++) cyc(1);
        cyc(1);
        chk(done, 1, "no done flag");
        chk(xs, ex, "x step count");
        chk(ys, ey, "y step count");
        chk(xpos, ex, "x position");
        chk(ypos, ey, "y position");
    endtask : wait_done
    task stop_move;
        contact <= 1'b0;
        cyc(10);
        chk(dirs, 0, "dir kept");
        chk(done, 0, "done kept");
    endtask : stop_move
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        contact = 1'b0;
        busy_a = 1'b0;
        busy_b = 1'b0;
        xc = 32'sh0;
        yc = 32'sh0;
        ex = 32'sh0;
        ey = 32'sh0;
        cyc(10);
        rst_n <= 1'b1;
        cyc(2);
        go(5, -3);
        wait_done();
        cyc(50);
        chk(dirs, 1, "dir hold");
        chk(alone, 0, "y pulse alone");
        stop_move();
        for (int ch = 0; ch < 2; ch++) begin
            busy_a <= (ch == 0);
            busy_b <= (ch == 1);
            go(-2, 4);
            cyc(300);
            chk(busy, 0, "started while busy");
            chk(xs, ex + 2, "pulsed while busy");
            busy_a <= 1'b0;
            busy_b <= 1'b0;
            wait_done();
            chk(dirs, 2, "dir");
            stop_move();
        end
        go(0, 0);
        wait_done();
        stop_move();
        go(100, -50);
        for (int k = 0; k < 5000 && xs < ex - 97; k++) cyc(1);
        chk({31'h0, xs >= ex - 97}, 1, "abort move stalled");
        contact <= 1'b0;
        cyc(10);
        chk(dirs, 0, "dir after abort");
        sx = xs;
        cyc(1500);
        chk(xs, sx, "pulses after contact drop");
        chk(xpos, xs, "x position after abort");
        chk(ypos, ys, "y position after abort");
        chk({31'h0, gap >= 32'h0000_01EF}, 1, "rate above clamp");
        wrap_up();
    end
    initial begin
        cyc(60000);
        err_total++;
        wrap_up();
    end
endmodule : two_axis_relative_pulse_gen_tb
